//--- llc_link_regs.sv
// link-layer control register bank with axi4-lite access and auto-ack selection
// Summary of operation
// R1 - writing one to set bit sets master
// R2 - writing one to clear bit clears master
// R3 - both registers read master; acts only when root
// R4 - mode zero: requests pending, responses complete
// R5 - mode one: read/lock pending, rest complete
// R6 - packet errors pick code by error kind
// R7 - link enable bit is read/write
// R8 - link init bit holds initialisation, readable
// R9 - link reset bit holds reset, readable
// R10 - reserved bits read zero, written zero
// R11 - reset: master, mode, enable one; others zero
`default_nettype none
module llc_link_regs (
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	input  wire logic [llc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [llc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       isRoot,
	input  wire logic                       pktDone,
	input  wire logic                       pktIsResponse,
	input  wire logic                       pktIsReadLock,
	input  wire logic [1:0]                 pktErr,
	output logic                            cycleMaster,
	output logic                            ackMode,
	output logic                            linkEnable,
	output logic                            linkInit,
	output logic                            linkReset,
	output logic                            cycleMasterActive,
	output logic                            ackValid,
	output logic [3:0]                      ackCode
);
	llc_regbus_if rb ();

	logic       wrSet;
	logic       wrClr;
	logic       wrAck;
	logic       wrIni;
	logic [9:0] wrIdx;
	logic [9:0] rdIdx;

	llc_axil_slave u_slave (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rb            (rb)
	);

	// register decode; a write whose low byte lane is off changes nothing
	assign wrIdx = llc_pkg::wordIndex(rb.wrAddr);
	assign rdIdx = llc_pkg::wordIndex(rb.rdAddr);
	assign wrSet = rb.wrEn && rb.wrLowByte && wrIdx == {2'b00, llc_pkg::IDX_CM_SET};
	assign wrClr = rb.wrEn && rb.wrLowByte && wrIdx == {2'b00, llc_pkg::IDX_CM_CLR};
	assign wrAck = rb.wrEn && rb.wrLowByte && wrIdx == {2'b00, llc_pkg::IDX_ACK_LEN};
	assign wrIni = rb.wrEn && rb.wrLowByte && wrIdx == {2'b00, llc_pkg::IDX_INI_RST};

	// shared cycle-master bit: one register sets it, the other clears it
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cycleMaster <= llc_pkg::RST_CYCLE_MASTER; // R11
		end else if (wrSet && rb.wrData[llc_pkg::BIT_CYCLE_MASTER]) begin
			cycleMaster <= 1'b1; // R1
		end else if (wrClr && rb.wrData[llc_pkg::BIT_CYCLE_MASTER]) begin
			cycleMaster <= 1'b0; // R2
		end
	end

	// master role takes effect only while this node is root
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			cycleMasterActive <= 1'b0;
		else
			cycleMasterActive <= cycleMaster && isRoot; // R3
	end

	// acknowledge mode and link enable; written bits outside the fields are dropped
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ackMode    <= llc_pkg::RST_ACK_MODE; // R11
			linkEnable <= llc_pkg::RST_LINK_ENABLE; // R11
		end else if (wrAck) begin
			ackMode    <= rb.wrData[llc_pkg::BIT_ACK_MODE];
			linkEnable <= rb.wrData[llc_pkg::BIT_LINK_ENABLE]; // R7
		end
	end

	// init and reset are plain levels held until software writes them back to zero
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			linkInit  <= llc_pkg::RST_LINK_INIT; // R11
			linkReset <= llc_pkg::RST_LINK_RESET; // R11
		end else if (wrIni) begin
			linkInit  <= rb.wrData[llc_pkg::BIT_LINK_INIT]; // R8
			linkReset <= rb.wrData[llc_pkg::BIT_LINK_RESET]; // R9
		end
	end

	// readback; every bit not listed reads zero
	always_comb begin
		rb.rdData = '0; // R10
		case (rdIdx)
			{2'b00, llc_pkg::IDX_CM_SET},
			{2'b00, llc_pkg::IDX_CM_CLR}: rb.rdData[llc_pkg::BIT_CYCLE_MASTER] = cycleMaster; // R3
			{2'b00, llc_pkg::IDX_ACK_LEN}: begin
				rb.rdData[llc_pkg::BIT_ACK_MODE]    = ackMode;
				rb.rdData[llc_pkg::BIT_LINK_ENABLE] = linkEnable; // R7
			end
			{2'b00, llc_pkg::IDX_INI_RST}: begin
				rb.rdData[llc_pkg::BIT_LINK_INIT]  = linkInit; // R8
				rb.rdData[llc_pkg::BIT_LINK_RESET] = linkReset; // R9
			end
			default: rb.rdData = '0;
		endcase
	end

	// acknowledge selection follows the live mode bit
	llc_ack_select u_ack (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.ackMode       (ackMode),
		.pktDone       (pktDone),
		.pktIsResponse (pktIsResponse),
		.pktIsReadLock (pktIsReadLock),
		.pktErr        (llc_pkg::llc_err_e'(pktErr)),
		.ackValid      (ackValid),
		.ackCode       (ackCode)
	);

	// checks
	a_cm_set_write: assert property (@(posedge sys_clk) disable iff (reset) // R1
		wrSet && rb.wrData[llc_pkg::BIT_CYCLE_MASTER] |=> cycleMaster)
		else $error("cycle master not set by set write");

	a_cm_clr_write: assert property (@(posedge sys_clk) disable iff (reset) // R2
		wrClr && rb.wrData[llc_pkg::BIT_CYCLE_MASTER] |=> !cycleMaster)
		else $error("cycle master not cleared by clear write");

	a_cm_zero_keeps: assert property (@(posedge sys_clk) disable iff (reset) // R2
		(wrSet || wrClr) && !rb.wrData[llc_pkg::BIT_CYCLE_MASTER]
		|=> $stable(cycleMaster))
		else $error("zero write moved cycle master");

	a_cm_active_root: assert property (@(posedge sys_clk) disable iff (reset) // R3
		##1 cycleMasterActive == ($past(cycleMaster) && $past(isRoot)))
		else $error("master role active without root");

	// the qualifiers are taken from the pktDone cycle; a packet right behind keeps the strobe up
	a_ack_mode_zero: assert property (@(posedge sys_clk) disable iff (reset) // R4
		pktDone && !ackMode && pktErr == 2'b00 |=> ackValid
		&& ackCode == ($past(pktIsResponse) ? llc_pkg::ACK_COMPLETE : llc_pkg::ACK_PENDING)
		##1 (!ackValid || $past(pktDone)))
		else $error("wrong ack code in mode zero");

	a_ack_mode_one: assert property (@(posedge sys_clk) disable iff (reset) // R5
		pktDone && ackMode && pktErr == 2'b00 && !pktIsResponse && !pktIsReadLock
		|=> ackValid && ackCode == 4'h1)
		else $error("write request not completed in mode one");

	a_ack_error: assert property (@(posedge sys_clk) disable iff (reset) // R6
		pktDone && pktErr == 2'b01 |=> ackValid && ackCode == 4'hd)
		else $error("data error code not returned");

	a_link_enable: assert property (@(posedge sys_clk) disable iff (reset) // R7
		wrAck |=> linkEnable == $past(rb.wrData[1]) && ackMode == $past(rb.wrData[3]))
		else $error("ack and enable register not written");

	a_init_hold: assert property (@(posedge sys_clk) disable iff (reset) // R8
		linkInit && !wrIni |=> linkInit)
		else $error("link init released without a write");

	// reset level follows a write and otherwise stays put
	a_reset_hold: assert property (@(posedge sys_clk) disable iff (reset) // R9
		##1 linkReset == ($past(wrIni) ? $past(rb.wrData[llc_pkg::BIT_LINK_RESET])
		: $past(linkReset)))
		else $error("link reset not taken from write or not held");

	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset) // R10
		s_axi_rvalid |-> s_axi_rdata[31:6] == '0 && s_axi_rdata[4] == 1'b0
		&& s_axi_rdata[2] == 1'b0)
		else $error("reserved bits read nonzero");

	a_reset_values: assert property (@(posedge sys_clk) // R11
		$fell(reset) |-> cycleMaster && ackMode && linkEnable && !linkInit && !linkReset)
		else $error("wrong values after reset");
endmodule
`default_nettype wire

//--- llc_pkg.sv
// constants and helpers shared by the link-layer control register bank
`default_nettype none
package llc_pkg;
	localparam int ADDR_W = 12;
	localparam int REG_W  = 16;
	// printed register indices; byte address is four times the index
	localparam logic [7:0] IDX_CM_SET  = 8'h3c;
	localparam logic [7:0] IDX_CM_CLR  = 8'h3e;
	localparam logic [7:0] IDX_ACK_LEN = 8'h40;
	localparam logic [7:0] IDX_INI_RST = 8'h42;
	// field positions
	localparam int BIT_CYCLE_MASTER = 5;
	localparam int BIT_ACK_MODE     = 3;
	localparam int BIT_LINK_ENABLE  = 1;
	localparam int BIT_LINK_INIT    = 1;
	localparam int BIT_LINK_RESET   = 0;
	// reset values
	localparam logic RST_CYCLE_MASTER = 1'b1;
	localparam logic RST_ACK_MODE     = 1'b1;
	localparam logic RST_LINK_ENABLE  = 1'b1;
	localparam logic RST_LINK_INIT    = 1'b0;
	localparam logic RST_LINK_RESET   = 1'b0;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// acknowledge codes returned to the far node
	localparam logic [3:0] ACK_COMPLETE   = 4'h1;
	localparam logic [3:0] ACK_PENDING    = 4'h2;
	localparam logic [3:0] ACK_DATA_ERROR = 4'hd;
	localparam logic [3:0] ACK_TYPE_ERROR = 4'he;
	// kind of error seen in a received packet
	typedef enum logic [1:0] {
		ERR_NONE = 2'b00,
		ERR_DATA = 2'b01,
		ERR_TYPE = 2'b10
	} llc_err_e;

	// word index of a byte address, or all ones when misaligned
	function automatic logic [9:0] wordIndex(input logic [ADDR_W-1:0] addr);
		wordIndex = (addr[1:0] == 2'b00) ? addr[ADDR_W-1:2] : 10'h3ff;
	endfunction

	// true when the byte address hits one of the four registers
	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = wordIndex(addr);
		isMapped = (idx == {2'b00, IDX_CM_SET}) || (idx == {2'b00, IDX_CM_CLR})
			|| (idx == {2'b00, IDX_ACK_LEN}) || (idx == {2'b00, IDX_INI_RST});
	endfunction
endpackage
`default_nettype wire

//--- llc_regbus_if.sv
// internal register access path between the bus slave and the register bank
`default_nettype none
interface llc_regbus_if;
	logic                           wrEn;
	logic [llc_pkg::ADDR_W-1:0]     wrAddr;
	logic [llc_pkg::REG_W-1:0]      wrData;
	logic                           wrLowByte;
	logic [llc_pkg::ADDR_W-1:0]     rdAddr;
	logic [llc_pkg::REG_W-1:0]      rdData;

	modport bus (
		output wrEn,
		output wrAddr,
		output wrData,
		output wrLowByte,
		output rdAddr,
		input  rdData
	);
	modport regs (
		input  wrEn,
		input  wrAddr,
		input  wrData,
		input  wrLowByte,
		input  rdAddr,
		output rdData
	);
endinterface
`default_nettype wire

//--- llc_axil_slave.sv
// axi4-lite slave that turns bus transfers into single-cycle register accesses
`default_nettype none
module llc_axil_slave (
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	input  wire logic [llc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [llc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	llc_regbus_if.bus                       rb
);
	logic                       awHeld;
	logic                       wHeld;
	logic [llc_pkg::ADDR_W-1:0] awAddr;
	logic [15:0]                wData;
	logic                       wLow;
	logic                       wrFire;

	// address and data may arrive in either order; each is held until both are in
	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign wrFire        = awHeld && wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	assign rb.wrEn      = wrFire;
	assign rb.wrAddr    = awAddr;
	assign rb.wrData    = wData;
	assign rb.wrLowByte = wLow;
	assign rb.rdAddr    = s_axi_araddr;

	// capture write address
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axi_awvalid && !awHeld) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (wrFire) begin
			awHeld <= 1'b0;
		end
	end

	// capture write data; only the low two lanes carry register bits
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wHeld <= 1'b0;
			wData <= '0;
			wLow  <= 1'b0;
		end else if (s_axi_wvalid && !wHeld) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata[15:0];
			wLow  <= s_axi_wstrb[0];
		end else if (wrFire) begin
			wHeld <= 1'b0;
		end
	end

	// write response raised on the same edge as the register update
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= llc_pkg::RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= llc_pkg::isMapped(awAddr) ? llc_pkg::RESP_OKAY
				: llc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read data registered from the bank; unmapped reads answer zero and an error
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= llc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rb.rdData};
			s_axi_rresp  <= llc_pkg::isMapped(s_axi_araddr) ? llc_pkg::RESP_OKAY
				: llc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- llc_ack_select.sv
// picks the acknowledge code returned for each received packet
`default_nettype none
module llc_ack_select (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              ackMode,
	input  wire logic              pktDone,
	input  wire logic              pktIsResponse,
	input  wire logic              pktIsReadLock,
	input  wire llc_pkg::llc_err_e pktErr,
	output logic                   ackValid,
	output logic [3:0]             ackCode
);
	logic [3:0] next_ackCode;

	// error kind takes priority over the mode; otherwise mode picks pending or complete
	always_comb begin
		case (pktErr)
			llc_pkg::ERR_DATA: next_ackCode = llc_pkg::ACK_DATA_ERROR; // R6
			llc_pkg::ERR_TYPE: next_ackCode = llc_pkg::ACK_TYPE_ERROR; // R6
			llc_pkg::ERR_NONE: begin
				if (pktIsResponse)
					next_ackCode = llc_pkg::ACK_COMPLETE; // R4
				else if (!ackMode || pktIsReadLock)
					next_ackCode = llc_pkg::ACK_PENDING; // R5
				else
					next_ackCode = llc_pkg::ACK_COMPLETE; // R5
			end
			default: next_ackCode = llc_pkg::ACK_TYPE_ERROR;
		endcase
	end

	// one-cycle strobe with the code, one cycle after the packet ends
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ackValid <= 1'b0;
			ackCode  <= 4'h0;
		end else begin
			ackValid <= pktDone;
			if (pktDone)
				ackCode <= next_ackCode;
		end
	end
endmodule
`default_nettype wire

//--- test_link_layer_control_regs.sv
// self-checking bench for the link-layer control register bank
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		checksDone++; \
		if ((got) !== (exp)) begin \
			nMismatch++; \
			$display("[ERR] %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_link_layer_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BOUND = 50;
	logic        sys_clk, reset, isRoot, pktDone, pktIsResponse, pktIsReadLock;
	logic [11:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0]  wStrb, ackCode;
	logic [1:0]  bResp, rResp, pktErr;
	logic        awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady, ackValid;
	logic        cycleMaster, ackMode, linkEnable, linkInit, linkReset, cycleMasterActive;
	int          nMismatch, checksDone;

	llc_link_regs i_dut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .isRoot(isRoot), .pktDone(pktDone),
		.pktIsResponse(pktIsResponse), .pktIsReadLock(pktIsReadLock), .pktErr(pktErr),
		.cycleMaster(cycleMaster), .ackMode(ackMode), .linkEnable(linkEnable),
		.linkInit(linkInit), .linkReset(linkReset), .cycleMasterActive(cycleMasterActive),
		.ackValid(ackValid), .ackCode(ackCode));

	// 50 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// printed offsets are word indices, so the byte address is four times them
	function automatic logic [11:0] byteAddr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic close_out;
		$display("mismatches %0d checks %0d", nMismatch, checksDone);
		if (nMismatch == 0 && checksDone > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic timedOut(input string what);
		nMismatch++;
		$display("[ERR] %s expected handshake seen none", what);
		close_out();
	endtask

	// address and data offered together; each released once taken, bready held until bvalid
	task automatic axiWrite(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		int n;
		@(posedge sys_clk);
		awAddr <= a;
		awValid <= 1'b1;
		wData <= {16'h0000, d};
		wStrb <= s;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (n = 0; n < BOUND; n++) begin
			@(posedge sys_clk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) begin
				resp = bResp;
				bReady <= 1'b0;
				break;
			end
		end
		if (n == BOUND) timedOut("write");
	endtask

	task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge sys_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (n = 0; n < BOUND; n++) begin
			@(posedge sys_clk);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) begin
				d = rData;
				resp = rResp;
				rReady <= 1'b0;
				break;
			end
		end
		if (n == BOUND) timedOut("read");
	endtask

	task automatic writeOk(input logic [7:0] idx, input logic [15:0] d);
		logic [1:0] r;
		axiWrite(byteAddr(idx), d, 4'hf, r);
		`CHK("bresp", llc_pkg::RESP_OKAY, r);
	endtask

	task automatic expectRead(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(a, d, r);
		`CHK("rdata", exp, d);
		`CHK("rresp", er, r);
	endtask

	// one packet strobe, then the code must show one edge later for exactly one cycle
	task automatic sendPkt(input logic resp, input logic rl, input logic [1:0] err,
		input logic [3:0] exp);
		@(posedge sys_clk);
		pktDone <= 1'b1;
		pktIsResponse <= resp;
		pktIsReadLock <= rl;
		pktErr <= err;
		@(posedge sys_clk);
		pktDone <= 1'b0;
		#1;
		`CHK("ackValid", 1'b1, ackValid);
		`CHK("ackCode", exp, ackCode);
		@(posedge sys_clk);
		#1;
		`CHK("ackValid low", 1'b0, ackValid);
	endtask

	task automatic testReset;
		`CHK("cycleMaster", 1'b1, cycleMaster);
		`CHK("ackMode", 1'b1, ackMode);
		`CHK("linkEnable", 1'b1, linkEnable);
		`CHK("linkInit", 1'b0, linkInit);
		`CHK("linkReset", 1'b0, linkReset);
		expectRead(byteAddr(llc_pkg::IDX_CM_SET), 32'h00000020, llc_pkg::RESP_OKAY);
		expectRead(byteAddr(llc_pkg::IDX_CM_CLR), 32'h00000020, llc_pkg::RESP_OKAY);
		expectRead(byteAddr(llc_pkg::IDX_ACK_LEN), 32'h0000000a, llc_pkg::RESP_OKAY);
		expectRead(byteAddr(llc_pkg::IDX_INI_RST), 32'h00000000, llc_pkg::RESP_OKAY);
		$display("reset values done");
	endtask

	task automatic testCycleMaster;
		@(posedge sys_clk);
		isRoot <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("active root", 1'b1, cycleMasterActive);
		writeOk(llc_pkg::IDX_CM_CLR, 16'h0000);
		`CHK("clear zero", 1'b1, cycleMaster);
		writeOk(llc_pkg::IDX_CM_CLR, 16'h0020);
		`CHK("clear one", 1'b0, cycleMaster);
		expectRead(byteAddr(llc_pkg::IDX_CM_SET), 32'h00000000, llc_pkg::RESP_OKAY);
		`CHK("active cleared", 1'b0, cycleMasterActive);
		writeOk(llc_pkg::IDX_CM_SET, 16'h0000);
		`CHK("set zero", 1'b0, cycleMaster);
		writeOk(llc_pkg::IDX_CM_SET, 16'h0020);
		`CHK("set one", 1'b1, cycleMaster);
		expectRead(byteAddr(llc_pkg::IDX_CM_CLR), 32'h00000020, llc_pkg::RESP_OKAY);
		@(posedge sys_clk);
		isRoot <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("active not root", 1'b0, cycleMasterActive);
		$display("cycle master done");
	endtask

	task automatic testLinkEnable;
		writeOk(llc_pkg::IDX_ACK_LEN, 16'h0000);
		`CHK("enable off", 1'b0, linkEnable);
		`CHK("mode off", 1'b0, ackMode);
		expectRead(byteAddr(llc_pkg::IDX_ACK_LEN), 32'h00000000, llc_pkg::RESP_OKAY);
		writeOk(llc_pkg::IDX_ACK_LEN, 16'h0002);
		`CHK("enable on", 1'b1, linkEnable);
		expectRead(byteAddr(llc_pkg::IDX_ACK_LEN), 32'h00000002, llc_pkg::RESP_OKAY);
		$display("link enable done");
	endtask

	// every packet kind and error kind, in both acknowledge modes
	task automatic testAck;
		logic [3:0] exp;
		logic [1:0] err;
		for (int m = 0; m < 2; m++) begin
			writeOk(llc_pkg::IDX_ACK_LEN, {12'h000, m[0], 3'b010});
			for (int k = 0; k < 6; k++) begin
				err = (k < 3) ? 2'b00 : k[1:0] - 2'b10;
				if (k == 5) err = 2'b11;
				if (err == 2'b01) exp = llc_pkg::ACK_DATA_ERROR;
				else if (err != 2'b00) exp = llc_pkg::ACK_TYPE_ERROR;
				else if (k == 2) exp = llc_pkg::ACK_COMPLETE;
				else if (m == 0 || k == 1) exp = llc_pkg::ACK_PENDING;
				else exp = llc_pkg::ACK_COMPLETE;
				sendPkt(k == 2, k == 1, err, exp);
			end
		end
		$display("ack select done");
	endtask

	task automatic testInitReset;
		writeOk(llc_pkg::IDX_INI_RST, 16'h0002);
		`CHK("init held", 1'b1, linkInit);
		`CHK("reset idle", 1'b0, linkReset);
		expectRead(byteAddr(llc_pkg::IDX_INI_RST), 32'h00000002, llc_pkg::RESP_OKAY);
		writeOk(llc_pkg::IDX_INI_RST, 16'h0001);
		`CHK("init released", 1'b0, linkInit);
		`CHK("reset held", 1'b1, linkReset);
		expectRead(byteAddr(llc_pkg::IDX_INI_RST), 32'h00000001, llc_pkg::RESP_OKAY);
		writeOk(llc_pkg::IDX_INI_RST, 16'h0000);
		`CHK("reset released", 1'b0, linkReset);
		$display("init reset done");
	endtask

	// unmapped and misaligned places must answer with an error and change nothing
	task automatic testUnmapped;
		logic [1:0] r;
		expectRead(12'h104, 32'h00000000, llc_pkg::RESP_SLVERR);
		axiWrite(byteAddr(llc_pkg::IDX_CM_CLR) + 12'h002, 16'h0020, 4'hf, r);
		`CHK("misaligned bresp", llc_pkg::RESP_SLVERR, r);
		`CHK("master kept", 1'b1, cycleMaster);
		// low byte lane off: the clear bit never reaches the register
		axiWrite(byteAddr(llc_pkg::IDX_CM_CLR), 16'h0020, 4'h0, r);
		`CHK("lane off bresp", llc_pkg::RESP_OKAY, r);
		`CHK("lane off kept", 1'b1, cycleMaster);
		$display("unmapped done");
	endtask

	// main sequence: inputs quiet at time zero, two cycles of reset
	initial begin
		{awAddr, arAddr, wData, wStrb, pktErr} = '0;
		{awValid, wValid, bReady, arValid, rReady} = '0;
		{isRoot, pktDone, pktIsResponse, pktIsReadLock} = '0;
		nMismatch = 0;
		checksDone = 0;
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		testReset();
		testCycleMaster();
		testLinkEnable();
		testAck();
		testInitReset();
		testUnmapped();
		close_out();
	end
endmodule
`default_nettype wire
